// ### pkg/tmr16_pkg.sv
package tmr16_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] CNT_LO_ADDR = 8'h00;
  localparam logic [7:0] CNT_HI_ADDR = 8'h04;
  localparam logic [7:0] CMPA_LO_ADDR = 8'h08;
  localparam logic [7:0] CMPA_HI_ADDR = 8'h0C;
  localparam logic [7:0] CMPB_LO_ADDR = 8'h10;
  localparam logic [7:0] CMPB_HI_ADDR = 8'h14;
  localparam logic [7:0] CAP_LO_ADDR = 8'h18;
  localparam logic [7:0] CAP_HI_ADDR = 8'h1C;
  localparam logic [7:0] CTRL_A_ADDR = 8'h20;
  localparam logic [7:0] CTRL_B_ADDR = 8'h24;
  localparam logic [7:0] IRQ_FLAG_ADDR = 8'h28;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h2C;
  localparam logic [7:0] POWER_ADDR = 8'h30;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  // control_reg_a: [1:0] mode low bits
  // control_reg_b: [7] filter enable, [6] capture edge, [5] capture source,
  //                [4:3] mode high bits, [2:0] clock select
  localparam int CB_FILT = 7;
  localparam int CB_EDGE = 6;
  localparam int CB_SRC = 5;
  localparam int FLG_OVF = 0;
  localparam int FLG_MA = 1;
  localparam int FLG_MB = 2;
  localparam int FLG_CAP = 5;

  // ----------------------------------------
  // Reset values and constants
  // ----------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic POWER_OFF_RST = 1'b1;
  localparam logic [15:0] BOTTOM_VAL = 16'h0000;
  localparam logic [15:0] MAX_VAL = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam int FILT_SAMPLES = 4;

  // Clock select codes
  localparam logic [2:0] CS_OFF = 3'h0;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler divide ratios minus one
  localparam logic [9:0] DIV8_M1 = 10'h007;
  localparam logic [9:0] DIV64_M1 = 10'h03F;
  localparam logic [9:0] DIV256_M1 = 10'h0FF;
  localparam logic [9:0] DIV1024_M1 = 10'h3FF;

endpackage

// ### hw/tmr16_filter.sv
`timescale 1ns/100ps
module tmr16_filter
  import tmr16_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic din,
  output logic dout
);

  logic [FILT_SAMPLES-1:0] hist_r;
  logic dout_r;
  wire all_one = &hist_r;
  wire all_zero = ~|hist_r;

  // ----------------------------------------
  // Four equal samples change the output
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hist_r <= '0;
      dout_r <= 1'b0;
    end
    else
    begin
      hist_r <= {hist_r[FILT_SAMPLES-2:0], din};
      if (all_one)
        dout_r <= 1'b1;
      else if (all_zero)
        dout_r <= 1'b0;
    end
  end

  assign dout = enable ? dout_r : din;

endmodule

// ### hw/tmr16_core.sv
// Behaviour
// - Control registers are plain 8-bit bytes
// - Interrupt flags visible, each masked separately
// - Prescaler or edge-selected pin clock; idle when off
// - Compare registers compared with counter continuously
// - Compare match sets channel match flag
// - Capture edge copies counter, optional filter
// - Compare A as TOP gives no PWM on wave_out_a; wave_out_b still gives PWM
// - Compare A TOP is double buffered in PWM modes; mode 4 loads compare A directly
// - Capture register usable as fixed TOP
// - BOTTOM when counter is zero
// - MAX when counter is all ones
// - TOP from fixed values, compare A or capture
// - One shared high-byte latch
// - Low-byte write loads whole register
// - Counter/capture low-byte read copies high byte into latch
// - Compare high reads bypass the latch
// - Counter/capture high reads return latch
// - CPU counter write beats clear and count
// - Capture writable only in capture-TOP modes
`timescale 1ns/100ps
module tmr16_core
  import tmr16_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_pin,
  input wire logic capture_pin,
  input wire logic comp_out,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic bottom_hit,
  output logic max_hit,
  output logic top_hit
);
  import tmr16_pkg::*;

  logic [1:0] rst_sync_r;
  wire rst_n = rst_sync_r[1];

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] count_value_r, count_value_nxt;
  logic [15:0] compare_a_value_r, compare_b_value_r;
  logic [15:0] cmpa_buf_r, cmpb_buf_r;
  logic [15:0] capture_value_r;
  logic [7:0] control_reg_a_r, control_reg_b_r;
  logic [7:0] irq_flag_reg_r, irq_mask_reg_r;
  logic [7:0] hi_latch_r;
  logic power_off_bit_r;
  logic dir_down_r;
  logic wave_a_r, wave_b_r;
  logic [9:0] presc_r;
  logic ext_d1_r, ext_d2_r;
  logic cap_d_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire [7:0] wb = pwdata[7:0];
  wire hit_cnt_lo = paddr == CNT_LO_ADDR;
  wire hit_cnt_hi = paddr == CNT_HI_ADDR;
  wire hit_a_lo = paddr == CMPA_LO_ADDR;
  wire hit_a_hi = paddr == CMPA_HI_ADDR;
  wire hit_b_lo = paddr == CMPB_LO_ADDR;
  wire hit_b_hi = paddr == CMPB_HI_ADDR;
  wire hit_cap_lo = paddr == CAP_LO_ADDR;
  wire hit_cap_hi = paddr == CAP_HI_ADDR;
  wire hit_ca = paddr == CTRL_A_ADDR;
  wire hit_cb = paddr == CTRL_B_ADDR;
  wire hit_flg = paddr == IRQ_FLAG_ADDR;
  wire hit_msk = paddr == IRQ_MASK_ADDR;
  wire hit_pwr = paddr == POWER_ADDR;
  wire mapped = hit_cnt_lo | hit_cnt_hi | hit_a_lo | hit_a_hi | hit_b_lo | hit_b_hi | hit_cap_lo
    | hit_cap_hi | hit_ca | hit_cb | hit_flg | hit_msk | hit_pwr;
  wire hi_wr = wr & (hit_cnt_hi | hit_a_hi | hit_b_hi | hit_cap_hi);
  wire cnt_wr = wr & hit_cnt_lo;
  wire cnt_lo_rd = rd & hit_cnt_lo;
  wire cap_lo_rd = rd & hit_cap_lo;

  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // ----------------------------------------
  // Mode and TOP selection
  // ----------------------------------------
  wire [3:0] mode = {control_reg_b_r[4:3], control_reg_a_r[1:0]};
  wire [2:0] clk_sel = control_reg_b_r[2:0];
  wire top_is_a = (mode == 4'd4) | (mode == 4'd9) | (mode == 4'd11) | (mode == 4'd15);
  wire top_is_cap = (mode == 4'd8) | (mode == 4'd10) | (mode == 4'd12) | (mode == 4'd14);
  wire pwm_mode = (mode != 4'd0) & (mode != 4'd4) & (mode != 4'd12);
  wire updown = (mode[1:0] != 2'd0) & ~mode[3] & ~mode[2] | (mode[3] & ~mode[2]);
  wire direct_a = ~pwm_mode;
  logic [15:0] top_val;

  always_comb
  begin
    unique case (1'b1)
      top_is_a: top_val = compare_a_value_r;
      top_is_cap: top_val = capture_value_r;
      default:
      begin
        unique case (mode[1:0])
          2'd1: top_val = TOP_8BIT;
          2'd2: top_val = TOP_9BIT;
          2'd3: top_val = TOP_10BIT;
          default: top_val = MAX_VAL;
        endcase
      end
    endcase
  end

  // ----------------------------------------
  // Timer tick
  // ----------------------------------------
  wire ext_edge_r = ext_d1_r & ~ext_d2_r;
  wire ext_edge_f = ~ext_d1_r & ext_d2_r;
  logic presc_hit;

  always_comb
  begin
    unique case (clk_sel)
      3'd2: presc_hit = (presc_r & DIV8_M1) == DIV8_M1;
      3'd3: presc_hit = (presc_r & DIV64_M1) == DIV64_M1;
      3'd4: presc_hit = (presc_r & DIV256_M1) == DIV256_M1;
      3'd5: presc_hit = presc_r == DIV1024_M1;
      default: presc_hit = 1'b0;
    endcase
  end

  wire timer_tick = ~power_off_bit_r & (clk_sel != CS_OFF) & (
    (clk_sel == 3'd1) | presc_hit | ((clk_sel == CS_EXT_FALL) & ext_edge_f)
    | ((clk_sel == CS_EXT_RISE) & ext_edge_r));

  // ----------------------------------------
  // Conditions
  // ----------------------------------------
  assign bottom_hit = count_value_r == BOTTOM_VAL;
  assign max_hit = count_value_r == MAX_VAL;
  assign top_hit = count_value_r == top_val;
  wire match_a = count_value_r == compare_a_value_r;
  wire match_b = count_value_r == compare_b_value_r;
  wire buf_update = updown ? top_hit : bottom_hit;

  always_comb
  begin
    count_value_nxt = count_value_r;
    if (cnt_wr)
      count_value_nxt = {hi_latch_r, wb};
    else if (timer_tick)
    begin
      if (updown)
        count_value_nxt = dir_down_r ? count_value_r - 16'h0001 : count_value_r + 16'h0001;
      else if (top_hit)
        count_value_nxt = BOTTOM_VAL;
      else
        count_value_nxt = count_value_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Capture path
  // ----------------------------------------
  wire cap_raw = control_reg_b_r[CB_SRC] ? comp_out : capture_pin;
  logic cap_filt;

  tmr16_filter u_filter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(control_reg_b_r[CB_FILT]),
    .din(cap_raw),
    .dout(cap_filt)
  );

  wire cap_edge = control_reg_b_r[CB_EDGE] ? (cap_filt & ~cap_d_r) : (~cap_filt & cap_d_r);
  wire cap_event = cap_edge & ~top_is_cap & ~power_off_bit_r;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [7:0] rd_byte;

  always_comb
  begin
    rd_byte = 8'h00;
    if (hit_cnt_lo) rd_byte = count_value_r[7:0];
    if (hit_cnt_hi | hit_cap_hi) rd_byte = hi_latch_r;
    if (hit_a_lo) rd_byte = compare_a_value_r[7:0];
    if (hit_a_hi) rd_byte = compare_a_value_r[15:8];
    if (hit_b_lo) rd_byte = compare_b_value_r[7:0];
    if (hit_b_hi) rd_byte = compare_b_value_r[15:8];
    if (hit_cap_lo) rd_byte = capture_value_r[7:0];
    if (hit_ca) rd_byte = control_reg_a_r;
    if (hit_cb) rd_byte = control_reg_b_r;
    if (hit_flg) rd_byte = irq_flag_reg_r;
    if (hit_msk) rd_byte = irq_mask_reg_r;
    if (hit_pwr) rd_byte = {7'h00, power_off_bit_r};
  end

  assign prdata = {24'h0000_00, rd_byte};

  // ----------------------------------------
  // Sequential state
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_value_r <= 16'h0000;
      compare_a_value_r <= 16'h0000;
      compare_b_value_r <= 16'h0000;
      cmpa_buf_r <= 16'h0000;
      cmpb_buf_r <= 16'h0000;
      capture_value_r <= 16'h0000;
      control_reg_a_r <= CTRL_RST;
      control_reg_b_r <= CTRL_RST;
      irq_flag_reg_r <= 8'h00;
      irq_mask_reg_r <= 8'h00;
      hi_latch_r <= 8'h00;
      power_off_bit_r <= POWER_OFF_RST;
      dir_down_r <= 1'b0;
      presc_r <= 10'h000;
      ext_d1_r <= 1'b0;
      ext_d2_r <= 1'b0;
      cap_d_r <= 1'b0;
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
    end
    else
    begin
      count_value_r <= count_value_nxt;
      presc_r <= (power_off_bit_r | clk_sel == CS_OFF) ? 10'h000 : presc_r + 10'h001;
      ext_d1_r <= ext_count_pin;
      ext_d2_r <= ext_d1_r;
      cap_d_r <= cap_filt;
      if (timer_tick & updown)
      begin
        if (top_hit)
          dir_down_r <= 1'b1;
        else if (bottom_hit)
          dir_down_r <= 1'b0;
      end
      if (hi_wr)
        hi_latch_r <= wb;
      else if (cnt_lo_rd)
        hi_latch_r <= count_value_r[15:8];
      else if (cap_lo_rd)
        hi_latch_r <= capture_value_r[15:8];
      if (wr & hit_a_lo)
        cmpa_buf_r <= {hi_latch_r, wb};
      if (wr & hit_b_lo)
        cmpb_buf_r <= {hi_latch_r, wb};
      if (direct_a | (timer_tick & buf_update))
      begin
        compare_a_value_r <= (wr & hit_a_lo & direct_a) ? {hi_latch_r, wb} : cmpa_buf_r;
        compare_b_value_r <= (wr & hit_b_lo & direct_a) ? {hi_latch_r, wb} : cmpb_buf_r;
      end
      if (wr & hit_cap_lo & top_is_cap)
        capture_value_r <= {hi_latch_r, wb};
      else if (cap_event)
        capture_value_r <= count_value_r;
      if (wr & hit_ca) control_reg_a_r <= wb;
      if (wr & hit_cb) control_reg_b_r <= wb;
      if (wr & hit_msk) irq_mask_reg_r <= wb & 8'h27;
      if (wr & hit_pwr) power_off_bit_r <= wb[0];
      // Flags: hardware set wins over write-one-to-clear
      for (int i = 0; i < 8; i++)
      begin
        if (wr & hit_flg & wb[i])
          irq_flag_reg_r[i] <= 1'b0;
      end
      if (timer_tick & (updown ? bottom_hit : top_hit)) irq_flag_reg_r[FLG_OVF] <= 1'b1;
      if (timer_tick & match_a) irq_flag_reg_r[FLG_MA] <= 1'b1;
      if (timer_tick & match_b) irq_flag_reg_r[FLG_MB] <= 1'b1;
      if (cap_event) irq_flag_reg_r[FLG_CAP] <= 1'b1;
      if (timer_tick & match_a & pwm_mode & ~top_is_a)
        wave_a_r <= updown ? ~dir_down_r : 1'b0;
      else if (timer_tick & bottom_hit & pwm_mode & ~updown)
        wave_a_r <= 1'b1;
      if (timer_tick & match_b & pwm_mode)
        wave_b_r <= updown ? ~dir_down_r : 1'b0;
      else if (timer_tick & bottom_hit & pwm_mode & ~updown)
        wave_b_r <= 1'b1;
      if (timer_tick & match_a & ~pwm_mode)
        wave_a_r <= ~wave_a_r;
      if (timer_tick & match_b & ~pwm_mode)
        wave_b_r <= ~wave_b_r;
    end
  end

  assign wave_out_a = wave_a_r & ~(pwm_mode & top_is_a);
  assign wave_out_b = wave_b_r;

endmodule

// ### test/tmr16_core_asserts.sv
`timescale 1ns/100ps
module tmr16_core_asserts
  import tmr16_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bottom_hit,
  input wire logic max_hit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Bus responses and byte-wise counter loads
  // ----------------------------------------
  sequence acc_s;
    psel && penable;
  endsequence
  sequence cnt_lo_s;
    psel && penable && pwrite && paddr == CNT_LO_ADDR;
  endsequence
  sequence cnt_hi_s(logic [7:0] b);
    psel && penable && pwrite && paddr == CNT_HI_ADDR && pwdata[7:0] == b;
  endsequence
  zero_wait_a: assert property (acc_s |-> pready) else $error("access phase without ready");
  unmapped_err_a: assert property (acc_s ##0 (paddr > POWER_ADDR || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc_s ##0 (paddr <= POWER_ADDR && paddr[1:0] == 2'b00) |-> !pslverr)
    else $error("mapped access refused");
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("error outside access phase");
  byte_read_a: assert property (acc_s ##0 !pwrite |-> prdata[31:8] == 24'h0000_00)
    else $error("read data wider than a byte");
  lo_nonzero_a: assert property (cnt_lo_s ##0 (pwdata[7:0] != 8'h00) |=> !bottom_hit)
    else $error("counter low write lost");
  lo_notmax_a: assert property (cnt_lo_s ##0 (pwdata[7:0] != 8'hFF) |=> !max_hit)
    else $error("counter low write lost");
  bottom_load_a: assert property (cnt_hi_s(8'h00) ##3 cnt_lo_s ##0 pwdata[7:0] == 8'h00 |=> bottom_hit)
    else $error("zero count not flagged");
  max_load_a: assert property (cnt_hi_s(8'hFF) ##3 cnt_lo_s ##0 pwdata[7:0] == 8'hFF |=> max_hit)
    else $error("full count not flagged");
endmodule
bind tmr16_core tmr16_core_asserts chk (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bottom_hit(bottom_hit), .max_hit(max_hit));

// ### test/tmr16_cpu_model.sv
`timescale 1ns/100ps
module tmr16_cpu_model
(
  input wire logic core_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic done,
  output logic [8:0] got
);
  initial
  begin
    {psel, penable, pwrite, done} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    got = 9'h000;
  end
  // One whole transfer at a time, never split
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0000_00, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    got <= {pslverr, prdata[7:0]};
    done <= !w;
    {psel, penable} <= 2'b00;
  endtask
  always @(posedge core_clk)
    if (done)
      done <= 1'b0;
endmodule

// ### test/testbench.sv
`timescale 1ns/100ps
module testbench;
  import tmr16_pkg::*;
  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, done;
  logic wave_out_a, wave_out_b, top_hit;
  logic [2:0] pins;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [8:0] got;
  logic [16:0] q[$];
  logic [16:0] e;
  logic [15:0] seed;
  int fail_count = 0, n_tests = 0, cyc = 0;
  tmr16_core dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_pin(pins[0]), .capture_pin(pins[1]), .comp_out(pins[2]), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .bottom_hit(), .max_hit(), .top_hit(top_hit));
  tmr16_cpu_model cpu (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .done(done), .got(got));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task test_done;
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [7:0] a, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] item %h: expected %h, seen %h", a, exp, seen);
    end
  endtask
  function logic [15:0] xs();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  task wr(input logic [7:0] a, input logic [7:0] d);
    cpu.xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [8:0] x);
    q.push_back({a, x});
    cpu.xfer(1'b0, a, 8'h00);
  endtask
  task wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a + 8'h04, v[15:8]);
    wr(a, v[7:0]);
  endtask
  task rd16(input logic [7:0] a, input logic [15:0] v);
    rd(a, {1'b0, v[7:0]});
    rd(a + 8'h04, {1'b0, v[15:8]});
  endtask
  task pulse(input int b, input int n);
    repeat (n)
    begin
      @(posedge core_clk) pins[b] <= 1'b1;
      repeat (8) @(posedge core_clk);
      pins[b] <= 1'b0;
      repeat (8) @(posedge core_clk);
    end
  endtask
  task tend(input string s);
    $display("test %s done", s);
  endtask
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (done)
    begin
      e = q.pop_front();
      chk(e[16:9], got, e[8:0]);
    end
    if (cyc == 20000)
    begin
      fail_count++;
      test_done();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [15:0] v;
    arst_n = 1'b0;
    pins = 3'h0;
    seed = 16'h7779;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(CTRL_A_ADDR, 9'h000);
    rd(POWER_ADDR, 9'h001);
    rd16(CNT_LO_ADDR, 16'h0000);
    rd(8'h34, 9'h100);
    repeat (4)
    begin
      v = xs();
      wr(CTRL_B_ADDR, v[7:0]);
      rd(CTRL_B_ADDR, {1'b0, v[7:0]});
    end
    wr(CTRL_B_ADDR, 8'h00);
    wr(POWER_ADDR, 8'h00);
    tend("reset and control");
    wr(CNT_HI_ADDR, 8'h01);
    rd(CNT_LO_ADDR, 9'h000);
    rd(CNT_HI_ADDR, 9'h000);
    wr16(CNT_LO_ADDR, 16'h01FF);
    rd16(CNT_LO_ADDR, 16'h01FF);
    wr16(CNT_LO_ADDR, 16'hFFFF);
    @(posedge core_clk);
    chk(8'hFF, {8'h00, top_hit}, 9'h001);
    wr16(CNT_LO_ADDR, 16'h0000);
    wr16(CMPA_LO_ADDR, 16'h1234);
    wr(CNT_HI_ADDR, 8'hAB);
    rd(CMPA_HI_ADDR, 9'h012);
    rd(CMPA_LO_ADDR, 9'h034);
    rd(CNT_HI_ADDR, 9'h0AB);
    wr(CMPB_LO_ADDR, 8'h56);
    rd16(CMPB_LO_ADDR, 16'hAB56);
    tend("shared latch");
    wr16(CAP_LO_ADDR, 16'h7788);
    rd16(CAP_LO_ADDR, 16'h0000);
    wr(CTRL_A_ADDR, 8'h02);
    wr(CTRL_B_ADDR, 8'h18);
    wr16(CAP_LO_ADDR, 16'h7788);
    rd16(CAP_LO_ADDR, 16'h7788);
    wr(CTRL_A_ADDR, 8'h00);
    wr(CTRL_B_ADDR, 8'h00);
    tend("capture write");
    wr16(CNT_LO_ADDR, 16'h0100);
    repeat (20) @(posedge core_clk);
    rd16(CNT_LO_ADDR, 16'h0100);
    for (int k = 0; k < 2; k++)
    begin
      wr(CTRL_B_ADDR, (k != 0) ? {5'h00, CS_EXT_RISE} : {5'h00, CS_EXT_FALL});
      pulse(0, 3);
      rd16(CNT_LO_ADDR, 16'h0103 + 16'(3 * k));
    end
    wr(CTRL_B_ADDR, 8'h00);
    tend("clock select");
    wr(CTRL_B_ADDR, 8'h40);
    wr(IRQ_FLAG_ADDR, 8'h27);
    pulse(1, 1);
    rd16(CAP_LO_ADDR, 16'h0106);
    rd(IRQ_FLAG_ADDR, 9'h020);
    wr(CTRL_B_ADDR, 8'hE0);
    wr(IRQ_FLAG_ADDR, 8'h27);
    wr16(CNT_LO_ADDR, 16'h2345);
    pulse(2, 1);
    rd16(CAP_LO_ADDR, 16'h2345);
    rd(IRQ_FLAG_ADDR, 9'h020);
    wr(CTRL_B_ADDR, 8'h00);
    tend("capture");
    wr16(CMPA_LO_ADDR, 16'h0005);
    wr16(CMPB_LO_ADDR, 16'h0007);
    wr16(CNT_LO_ADDR, 16'h0000);
    wr(IRQ_FLAG_ADDR, 8'h27);
    wr(CTRL_B_ADDR, 8'h01);
    repeat (30) @(posedge core_clk);
    chk(8'hFF, {7'h00, wave_out_a, wave_out_b}, 9'h003);
    wr(CTRL_B_ADDR, 8'h00);
    rd(IRQ_FLAG_ADDR, 9'h006);
    wr(IRQ_MASK_ADDR, 8'h27);
    rd(IRQ_MASK_ADDR, 9'h027);
    wr(IRQ_FLAG_ADDR, 8'h06);
    rd(IRQ_FLAG_ADDR, 9'h000);
    tend("match and flags");
    repeat (3) @(posedge core_clk);
    test_done();
  end
endmodule
